// ### design/rlcdp_pkg.sv
// package: constants and types for the rotate-left-through-carry datapath
package rlcdp_pkg;
  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 12;
  localparam logic [7:0]  ILO_LIMIT      = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0]  DATA_RST       = 8'h00;
  localparam logic [11:0] ADDR_RST       = 12'h000;
  localparam logic [5:0]  OPC_ROT_CARRY  = 6'h0D;
  localparam int          OPC_LSB        = 10;
  localparam int          DEST_BIT       = 9;
  localparam int          ACC_BIT        = 8;

  typedef enum logic [1:0] {
    RLCDP_Q1,
    RLCDP_Q2,
    RLCDP_Q3,
    RLCDP_Q4
  } rlcdp_phase_t;
endpackage

// ### design/rlcdp_if.sv
// interface: address resolver request and answer
`timescale 1ns/100ps
interface rlcdp_if;
  import rlcdp_pkg::*;
  logic [7:0]  f_addr;
  logic        acc_sel;
  logic        ext_en;
  logic [3:0]  bank;
  logic [7:0]  index_base;
  logic [11:0] eff_addr;

  modport core (output f_addr, acc_sel, ext_en, bank, index_base, input eff_addr);
  modport resolver (input f_addr, acc_sel, ext_en, bank, index_base, output eff_addr);
endinterface

// ### design/rlcdp_addr.sv
// module: file address resolution
`timescale 1ns/100ps
module rlcdp_addr
  import rlcdp_pkg::*;
(
  rlcdp_if.resolver ai
);
  logic [11:0] sum;

  always_comb begin
    sum = {4'h0, ai.f_addr} + {4'h0, ai.index_base};
    // RQ6: indexed literal offset
    if (!ai.acc_sel && ai.ext_en && ai.f_addr <= ILO_LIMIT) begin
      sum = {4'h0, ai.f_addr} + {4'h0, ai.index_base};
      ai.eff_addr = sum;
    // RQ4: access bank mapping
    end else if (!ai.acc_sel) begin
      ai.eff_addr = (ai.f_addr < ACCESS_SPLIT) ? {4'h0, ai.f_addr} : {ACCESS_HI_BANK, ai.f_addr};
    // RQ5: bank select register
    end else begin
      ai.eff_addr = {ai.bank, ai.f_addr};
    end
  end
endmodule

// ### design/rlcdp_top.sv
// module: rotate-left-through-carry execution datapath
//
// Function
// RQ1: rotate file register left one bit; bit 7 to carry, carry to bit 0.
// RQ2: destination bit 0 writes result to working register, file untouched.
// RQ3: destination bit 1 writes result back to the file register.
// RQ4: access bit 0 maps file address into the access bank.
// RQ5: access bit 1 uses bank select register to choose the bank.
// RQ6: access 0 with extended set and address up to 5Fh uses indexed offset.
// RQ7: one instruction cycle: decode, read, rotate, write over four phases; the code takes five clocks, an extra Q1 accepts the start.
`timescale 1ns/100ps
module rlcdp_top
  import rlcdp_pkg::*;
(
  // clock, reset and instruction request
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        START,
  input  wire logic [15:0] OPCODE,
  // addressing context and operand sources
  input  wire logic        EXT_EN,
  input  wire logic [3:0]  BANK_SEL,
  input  wire logic [7:0]  INDEX_BASE,
  input  wire logic [7:0]  CARRY_IN,
  input  wire logic [7:0]  W_IN,
  input  wire logic [7:0]  RD_DATA,
  // sequencer status and file memory port
  output logic             BUSY,
  output logic             ILLEGAL,
  output logic [11:0]      RD_ADDR,
  output logic             RD_EN,
  output logic [11:0]      WR_ADDR,
  output logic [7:0]       WR_DATA,
  output logic             WR_EN,
  // destinations and status flags
  output logic [7:0]       W_OUT,
  output logic             W_WE,
  output logic             C_OUT,
  output logic             N_OUT,
  output logic             Z_OUT,
  output logic             FLAGS_WE,
  output logic             DONE
);
  import rlcdp_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // the datapath is wired for byte operands and 12-bit file addresses
  generate
    if (DATA_W != 8) begin : g_chk_data_w
      $error("rlcdp_top: operand width must be 8 bits");
    end
    if (ADDR_W != 12) begin : g_chk_addr_w
      $error("rlcdp_top: file address width must be 12 bits");
    end
    // indexed window must sit inside the low half of the access bank
    if (ILO_LIMIT >= ACCESS_SPLIT) begin : g_chk_ilo
      $error("rlcdp_top: indexed window overlaps the upper access half");
    end
    // opcode, destination and access fields must tile the word
    if (OPC_LSB != DEST_BIT + 1 || DEST_BIT != ACC_BIT + 1 || ACC_BIT != 8) begin : g_chk_fields
      $error("rlcdp_top: opcode field layout does not match the decoder");
    end
  endgenerate

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    rlcdp_phase_t phase;
    logic         busy;
    logic         illegal;
    logic [15:0]  op;
    logic [11:0]  addr;
    logic         rd_en;
    logic [7:0]   operand;
    logic         cin;
    logic [7:0]   result;
    logic         cout;
    logic [11:0]  wr_addr;
    logic [7:0]   wr_data;
    logic         wr_en;
    logic [7:0]   w;
    logic         w_we;
    logic         n;
    logic         z;
    logic         flags_we;
    logic         done;
  } rlcdp_state_t;

  rlcdp_state_t s_reg;
  rlcdp_state_t s_next;
  rlcdp_if      ai ();

  // ----------------------------------------
  // address resolution
  // ----------------------------------------
  assign ai.f_addr     = s_reg.op[7:0];
  assign ai.acc_sel    = s_reg.op[ACC_BIT];
  assign ai.ext_en     = EXT_EN;
  assign ai.bank       = BANK_SEL;
  assign ai.index_base = INDEX_BASE;

  rlcdp_addr u_addr (
    .ai (ai)
  );

  // ----------------------------------------
  // rotate network
  // ----------------------------------------
  // each result bit takes its right-hand neighbour; bit 0 takes the carry
  logic [7:0] rot_val;

  // RQ1: shift left through carry
  for (genvar b = 0; b < 8; b++) begin : g_rot
    if (b == 0) begin : g_carry
      assign rot_val[b] = s_reg.cin;
    end else begin : g_shift
      assign rot_val[b] = s_reg.operand[b - 1];
    end
  end

  // ----------------------------------------
  // sequencer and datapath
  // ----------------------------------------
  always_comb begin
    s_next          = s_reg;
    // strobes are one-cycle pulses, low unless a phase raises them
    s_next.rd_en    = 1'b0;
    s_next.wr_en    = 1'b0;
    s_next.w_we     = 1'b0;
    s_next.flags_we = 1'b0;
    s_next.done     = 1'b0;
    s_next.illegal  = 1'b0;
    // RQ7: four phase sequence
    case (s_reg.phase)
      RLCDP_Q1: begin
        // a start while busy is never looked at here
        if (s_reg.busy) begin
          // address from latched operand with live bank and index
          s_next.addr  = ai.eff_addr;
          s_next.rd_en = 1'b1;
          s_next.phase = RLCDP_Q2;
        end else if (START) begin
          if (OPCODE[15:OPC_LSB] == OPC_ROT_CARRY) begin
            s_next.op   = OPCODE;
            s_next.cin  = CARRY_IN[0];
            s_next.busy = 1'b1;
          end else begin
            s_next.illegal = 1'b1;
          end
        end
      end
      RLCDP_Q2: begin
        s_next.operand = RD_DATA;
        s_next.phase   = RLCDP_Q3;
      end
      RLCDP_Q3: begin
        // RQ1: rotate through carry
        s_next.result = rot_val;
        s_next.cout   = s_reg.operand[7];
        s_next.phase  = RLCDP_Q4;
      end
      RLCDP_Q4: begin
        // RQ2: result to working register
        if (!s_reg.op[DEST_BIT]) begin
          s_next.w    = s_reg.result;
          s_next.w_we = 1'b1;
        // RQ3: result back to file
        end else begin
          s_next.wr_addr = s_reg.addr;
          s_next.wr_data = s_reg.result;
          s_next.wr_en   = 1'b1;
        end
        // status bits follow the result whichever destination is used
        s_next.n        = s_reg.result[7];
        s_next.z        = (s_reg.result == DATA_RST);
        s_next.flags_we = 1'b1;
        s_next.done     = 1'b1;
        s_next.busy     = 1'b0;
        s_next.phase    = RLCDP_Q1;
      end
      default: begin
        s_next.phase = RLCDP_Q1;
        s_next.busy  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      s_reg         <= '0;
      s_reg.phase   <= RLCDP_Q1;
      s_reg.addr    <= ADDR_RST;
      s_reg.wr_addr <= ADDR_RST;
      s_reg.w       <= DATA_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign BUSY     = s_reg.busy;
  assign ILLEGAL  = s_reg.illegal;
  assign RD_ADDR  = s_reg.addr;
  assign RD_EN    = s_reg.rd_en;
  assign WR_ADDR  = s_reg.wr_addr;
  assign WR_DATA  = s_reg.wr_data;
  assign WR_EN    = s_reg.wr_en;
  assign W_OUT    = s_reg.w;
  assign W_WE     = s_reg.w_we;
  assign C_OUT    = s_reg.cout;
  assign N_OUT    = s_reg.n;
  assign Z_OUT    = s_reg.z;
  assign FLAGS_WE = s_reg.flags_we;
  assign DONE     = s_reg.done;
endmodule

// ### sim/rlcdp_monitor.sv
// checker: port assertions for the rotate datapath
`timescale 1ns/100ps
module rlcdp_monitor
  import rlcdp_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        START,
  input wire logic        EXT_EN,
  input wire logic        BUSY,
  input wire logic        RD_EN,
  input wire logic        WR_EN,
  input wire logic        W_WE,
  input wire logic        C_OUT,
  input wire logic        DONE,
  input wire logic [15:0] OPCODE,
  input wire logic [3:0]  BANK_SEL,
  input wire logic [7:0]  INDEX_BASE,
  input wire logic [7:0]  CARRY_IN,
  input wire logic [7:0]  RD_DATA,
  input wire logic [7:0]  WR_DATA,
  input wire logic [7:0]  W_OUT,
  input wire logic [11:0] RD_ADDR
);
  logic [7:0] f;
  logic       go;
  logic       ilo;
  assign f   = OPCODE[7:0];
  assign go  = START && !BUSY && OPCODE[15:10] == OPC_ROT_CARRY;
  assign ilo = !OPCODE[8] && EXT_EN && f <= ILO_LIMIT;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // read strobe, then done pulse three cycles on
  sequence s_step;
    RD_EN ##3 DONE;
  endsequence
  property p_cycle;
    go |-> ##[2:3] s_step;
  endproperty
  a_cycle: assert property (p_cycle) else $error("rotate not done in time");
  property p_rotate;
    logic       c;
    logic [7:0] d;
    (go, c = CARRY_IN[0]) ##[2:3] (RD_EN, d = RD_DATA) ##3 DONE
      |-> C_OUT == d[7] && (W_WE ? W_OUT : WR_DATA) == {d[6:0], c};
  endproperty
  a_rotate: assert property (p_rotate) else $error("wrong rotate result");
  property p_to_w;
    (go && !OPCODE[9]) ##[2:3] s_step |-> W_WE && !WR_EN;
  endproperty
  a_to_w: assert property (p_to_w) else $error("result not sent to working reg");
  property p_to_f;
    (go && OPCODE[9]) ##[2:3] s_step |-> WR_EN && !W_WE;
  endproperty
  a_to_f: assert property (p_to_f) else $error("result not written back");
  property p_access;
    logic [11:0] e;
    (go && !OPCODE[8] && !ilo, e = {f[7] ? ACCESS_HI_BANK : 4'h0, f}) ##[2:3] RD_EN |-> RD_ADDR == e;
  endproperty
  a_access: assert property (p_access) else $error("bad access bank address");
  property p_banked;
    logic [11:0] e;
    (go && OPCODE[8], e = {BANK_SEL, f}) ##[2:3] RD_EN |-> RD_ADDR == e;
  endproperty
  a_banked: assert property (p_banked) else $error("bad banked address");
  property p_indexed;
    logic [11:0] e;
    (go && ilo, e = 12'(INDEX_BASE) + 12'(f)) ##[2:3] RD_EN |-> RD_ADDR == e;
  endproperty
  a_indexed: assert property (p_indexed) else $error("bad indexed address");
endmodule

bind rlcdp_top rlcdp_monitor mon (.*);

// ### sim/rlcdp_test.sv
// testbench: directed rotate cases at the datapath ports
`timescale 1ns/100ps
module rlcdp_test;
  import rlcdp_pkg::*;
  // edges from the taking edge to the edge that raises the done pulse
  localparam int DONE_EDGES = 4;
  logic        MCLK = 1'b0;
  logic        RST = 1'b1;
  logic        START = 1'b0;
  logic        EXT_EN = 1'b0;
  logic [15:0] OPCODE = 16'h0000;
  logic [3:0]  BANK_SEL = 4'h5;
  logic [7:0]  INDEX_BASE = 8'h10;
  logic [7:0]  CARRY_IN = 8'h00;
  logic [7:0]  W_IN = 8'h00;
  logic [7:0]  RD_DATA = 8'h00;
  logic        BUSY, ILLEGAL, RD_EN, WR_EN, W_WE, C_OUT, N_OUT, Z_OUT, FLAGS_WE, DONE;
  logic [11:0] RD_ADDR, WR_ADDR;
  logic [7:0]  WR_DATA, W_OUT;
  int          err_count = 0;
  int          n_tests = 0;
  rlcdp_top DUT (
    .MCLK       (MCLK),
    .RST        (RST),
    .START      (START),
    .OPCODE     (OPCODE),
    .EXT_EN     (EXT_EN),
    .BANK_SEL   (BANK_SEL),
    .INDEX_BASE (INDEX_BASE),
    .CARRY_IN   (CARRY_IN),
    .W_IN       (W_IN),
    .RD_DATA    (RD_DATA),
    .BUSY       (BUSY),
    .ILLEGAL    (ILLEGAL),
    .RD_ADDR    (RD_ADDR),
    .RD_EN      (RD_EN),
    .WR_ADDR    (WR_ADDR),
    .WR_DATA    (WR_DATA),
    .WR_EN      (WR_EN),
    .W_OUT      (W_OUT),
    .W_WE       (W_WE),
    .C_OUT      (C_OUT),
    .N_OUT      (N_OUT),
    .Z_OUT      (Z_OUT),
    .FLAGS_WE   (FLAGS_WE),
    .DONE       (DONE)
  );
  initial forever #2 MCLK = ~MCLK;
  task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: address %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: data %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: flag %0b, expected %0b", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one rotate: dest, access, extended, address, file value, carry
  task automatic op(input logic d, a, x, input logic [7:0] f, v, input logic c);
    logic [11:0] ea;
    logic [7:0]  res;
    int          i;
    ea = a ? {BANK_SEL, f} : (x && f <= ILO_LIMIT) ? 12'(INDEX_BASE) + 12'(f) : {f[7] ? ACCESS_HI_BANK : 4'h0, f};
    res = {v[6:0], c};
    @(negedge MCLK);
    OPCODE = {OPC_ROT_CARRY, d, a, f};
    CARRY_IN = {7'h00, c};
    RD_DATA = v;
    EXT_EN = x;
    START = 1'b1;
    @(negedge MCLK);
    START = 1'b0;
    chk_bit(BUSY, 1'b1);
    i = 0;
    while (DONE !== 1'b1 && i < 20) begin
      @(posedge MCLK);
      #1;
      i++;
    end
    chk_data(8'(i), 8'(DONE_EDGES));
    chk_bit(BUSY, 1'b0);
    chk_addr(RD_ADDR, ea);
    chk_bit(W_WE, !d);
    chk_bit(WR_EN, d);
    if (d) chk_addr(WR_ADDR, ea);
    chk_data(d ? WR_DATA : W_OUT, res);
    chk_bit(C_OUT, v[7]);
    chk_bit(FLAGS_WE, 1'b1);
    chk_bit(N_OUT, res[7]);
    chk_bit(Z_OUT, res == 8'h00);
    @(negedge MCLK);
  endtask
  // a start with a foreign opcode while idle: refused with one illegal pulse
  task automatic bad_op(input logic [15:0] code);
    @(negedge MCLK);
    OPCODE = code;
    START = 1'b1;
    @(negedge MCLK);
    START = 1'b0;
    chk_bit(ILLEGAL, 1'b1);
    chk_bit(BUSY, 1'b0);
    @(negedge MCLK);
    chk_bit(ILLEGAL, 1'b0);
  endtask
  initial begin
    repeat (12) @(negedge MCLK);
    RST = 1'b0;
    op(1'b0, 1'b0, 1'b0, 8'h25, 8'hE6, 1'b0);
    op(1'b1, 1'b1, 1'b1, 8'hFF, 8'h81, 1'b1);
    op(1'b1, 1'b0, 1'b1, 8'h5F, 8'h7F, 1'b1);
    op(1'b0, 1'b0, 1'b1, 8'h60, 8'h00, 1'b0);
    op(1'b1, 1'b0, 1'b0, 8'h80, 8'h55, 1'b1);
    bad_op(16'h4425);
    op(1'b0, 1'b1, 1'b0, 8'h5F, 8'h80, 1'b0);
    end_sim;
  end
  initial begin
    #2000;
    err_count++;
    end_sim;
  end
endmodule
